//--- pnpp_monitor.sv
// Purpose: timing checks on the programming pins and register bus
// Assumes: one clock, synchronous active-low reset
// Notes: attached to every port instance by the bind at the foot
`timescale 1ns/1ps
module pnpp_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic hv_reset,
	input wire logic write_strobe_n,
	input wire logic output_enable_n,
	input wire logic data_oe,
	input wire logic ready_busy_flag,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// busy start and the strobe fall that must cause it
	sequence s_busy_start;
		$fell(ready_busy_flag);
	endsequence
	sequence s_wr_fell;
		$past(write_strobe_n, 2) && !$past(write_strobe_n);
	endsequence
	a_busy_cause: assert property (s_busy_start |-> s_wr_fell)
		else $error("busy began without a write strobe fall");
	a_busy_hold: assert property (s_busy_start |-> !ready_busy_flag [*8])
		else $error("busy flag returned too soon");
	a_oe_cause: assert property (data_oe |-> !$past(output_enable_n))
		else $error("bus driven without output enable");
	a_oe_release: assert property ($rose(output_enable_n) |=> !data_oe)
		else $error("bus still driven after output enable rose");
	a_off_quiet: assert property (!hv_reset [*3] |-> !data_oe)
		else $error("bus driven outside programming mode");
	a_b_follow: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_r_follow: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_r_stand: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
endmodule
bind pnpp_port pnpp_monitor pnpp_monitor_i (.*);

//--- pnpp_pkg.sv
// Purpose: shared constants for the parallel nvm programming port
// Assumes: 25 MHz system clock, pins already synchronous to it
// Notes: timing figures are kept in their printed units
package pnpp_pkg;
	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 25;
	localparam int CLK_PERIOD_NS = 40;
	localparam int T_GUARD_NS = 100;
	localparam int T_PROG_US = 3700;
	localparam int T_ERASE_US = 7500;
	localparam int GUARD_CYC = (T_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROG_CYC = T_PROG_US * CLK_MHZ;
	localparam int ERASE_CYC = T_ERASE_US * CLK_MHZ;
	localparam int TMR_W = 18;
	localparam logic [2:0] ENTRY_PULSES = 3'h6;
	localparam logic [3:0] ENTRY_PATTERN = 4'h0;

	// ----------------------------------------------------------------
	// action select and command codes
	// ----------------------------------------------------------------
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD = 2'h2;
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_WFUSE = 8'h40;
	localparam logic [7:0] CMD_WLOCK = 8'h20;
	localparam logic [7:0] CMD_WFLASH = 8'h10;
	localparam logic [7:0] CMD_WEEP = 8'h11;
	localparam logic [7:0] CMD_RFUSE = 8'h04;
	localparam logic [7:0] CMD_RFLASH = 8'h02;
	localparam logic [7:0] CMD_REEP = 8'h03;

	// ----------------------------------------------------------------
	// memory geometry
	// ----------------------------------------------------------------
	localparam int FL_AW = 15;
	localparam int FL_WORDS = 32768;
	localparam int FL_PAGE_W = 7;
	localparam int FL_PAGE = 128;
	localparam int EE_AW = 11;
	localparam int EE_BYTES = 2048;
	localparam int EE_PAGE_W = 3;
	localparam int EE_PAGE = 8;
	localparam logic [15:0] FL_ERASED = 16'hffff;
	localparam logic [7:0] EE_ERASED = 8'hff;

	// ----------------------------------------------------------------
	// fuse and lock layout
	// ----------------------------------------------------------------
	localparam logic [7:0] FUSE_LO_RST = 8'hff;
	localparam logic [7:0] FUSE_HI_RST = 8'hff;
	localparam logic [7:0] FUSE_EXT_RST = 8'hff;
	localparam logic [7:0] LOCK_RST = 8'hff;
	localparam int EE_KEEP_BIT = 3;
	localparam int LOCK_FUSE_BIT = 0;

	// ----------------------------------------------------------------
	// axi4-lite register map
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_CTRL = 4'h4;
	localparam logic [3:0] REG_ADDR = 4'h8;
	localparam logic [3:0] REG_FUSES = 4'hc;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// state types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ENT_OFF = 2'b00,
		ENT_GUARD = 2'b01,
		ENT_PROG = 2'b10,
		ENT_FAIL = 2'b11
	} pnpp_ent_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WAIT = 3'b001,
		ST_WALK_F = 3'b010,
		ST_WALK_E = 3'b011,
		ST_ERASE_F = 3'b100,
		ST_ERASE_E = 3'b101
	} pnpp_st_e;
	typedef enum logic [2:0] {
		OP_ERASE = 3'b000,
		OP_FLASH = 3'b001,
		OP_EEP = 3'b010,
		OP_FUSE = 3'b011,
		OP_LOCK = 3'b100
	} pnpp_op_e;
endpackage

//--- pnpp_port.sv
// Purpose: parallel programming port for flash, eeprom, fuses and lock
// Assumes: all pins synchronous to aclk; hv_reset high = programming volts
// Notes: status and control also reachable over axi4-lite
//
// Contract
// - pattern change within 100 ns refuses entry
// - command and address registers persist across operations
// - clock pulse loads command, address or data
// - byte select picks low or high byte
// - erase command plus write strobe starts chip erase
// - erase clears flash, lock bits, then eeprom
// - eeprom keep fuse preserves eeprom on erase
// - write flash loads data bytes into staging
// - page latch with select high buffers word
// - low bits pick word, high bits pick page
// - write strobe programs whole flash page, busy
// - no-op command resets internal write signals
// - eeprom write buffers bytes then programs page
// - read flash drives low or high byte
// - read eeprom drives addressed byte
// - fuse write targets low, high or extended
// - lock bits only cleared by chip erase
// - fuse and lock read chosen by selects
// - ready flag low while self-timed op runs
// - data bus driven only while output enable low
`timescale 1ns/1ps
module pnpp_port #(
	parameter int PROG_CYCLES = pnpp_pkg::PROG_CYC,
	parameter int ERASE_CYCLES = pnpp_pkg::ERASE_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic hv_reset,
	input wire logic load_strobe_clock_pin,
	input wire logic action_select_hi,
	input wire logic action_select_lo,
	input wire logic low_high_byte_select,
	input wire logic extended_byte_select,
	input wire logic page_latch_strobe,
	input wire logic write_strobe_n,
	input wire logic output_enable_n,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	output logic ready_busy_flag,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ----------------------------------------------------------------
	// storage and state
	// ----------------------------------------------------------------
	logic [15:0] flash_mem [pnpp_pkg::FL_WORDS];
	logic [7:0] eep_mem [pnpp_pkg::EE_BYTES];
	logic [15:0] fbuf [pnpp_pkg::FL_PAGE];
	logic [7:0] ebuf [pnpp_pkg::EE_PAGE];
	logic [pnpp_pkg::FL_PAGE-1:0] fvalid_q;
	logic [pnpp_pkg::EE_PAGE-1:0] evalid_q;
	logic [7:0] cmd_q;
	logic [15:0] addr_q;
	logic [7:0] dlo_q;
	logic [7:0] dhi_q;
	logic [7:0] fuse_lo_q;
	logic [7:0] fuse_hi_q;
	logic [7:0] fuse_ext_q;
	logic [7:0] lock_q;
	logic [1:0] fsel_q;
	pnpp_pkg::pnpp_ent_e ent_q;
	pnpp_pkg::pnpp_st_e st_q;
	pnpp_pkg::pnpp_op_e op_q;
	logic [2:0] pulses_q;
	logic [1:0] guard_q;
	logic [pnpp_pkg::TMR_W-1:0] tmr_q;
	logic [pnpp_pkg::FL_AW-1:0] idx_q;
	logic clk_pin_q;
	logic wr_n_q;
	logic pl_q;
	logic entry_en_q;

	// pin edges and derived terms
	logic clk_rise;
	logic wr_fall;
	logic pl_rise;
	logic prog;
	logic idle;
	logic [1:0] act;
	logic [3:0] pattern;
	logic tmr_done;
	logic fuse_commit;
	logic lock_commit;
	logic flash_done;
	logic eep_done;
	logic erase_e_done;
	logic ee_keep;
	logic [pnpp_pkg::FL_AW-1:0] fl_waddr;
	logic [pnpp_pkg::EE_AW-1:0] ee_waddr;

	assign clk_rise = load_strobe_clock_pin && !clk_pin_q;
	assign wr_fall = !write_strobe_n && wr_n_q;
	assign pl_rise = page_latch_strobe && !pl_q;
	assign prog = (ent_q == pnpp_pkg::ENT_PROG);
	assign idle = (st_q == pnpp_pkg::ST_IDLE);
	assign act = {action_select_hi, action_select_lo};
	assign pattern = {page_latch_strobe, action_select_hi, action_select_lo,
		low_high_byte_select};
	assign tmr_done = (st_q == pnpp_pkg::ST_WAIT) && (tmr_q == '0);
	assign fuse_commit = tmr_done && (op_q == pnpp_pkg::OP_FUSE);
	assign lock_commit = tmr_done && (op_q == pnpp_pkg::OP_LOCK);
	assign flash_done = (st_q == pnpp_pkg::ST_WALK_F) &&
		(idx_q[pnpp_pkg::FL_PAGE_W-1:0] == '1);
	assign eep_done = (st_q == pnpp_pkg::ST_WALK_E) &&
		(idx_q[pnpp_pkg::EE_PAGE_W-1:0] == '1);
	assign erase_e_done = (st_q == pnpp_pkg::ST_ERASE_E) &&
		(idx_q[pnpp_pkg::EE_AW-1:0] == '1);
	assign ee_keep = !fuse_hi_q[pnpp_pkg::EE_KEEP_BIT];
	// page from high address bits, word from walk index
	assign fl_waddr = {addr_q[pnpp_pkg::FL_AW-1:pnpp_pkg::FL_PAGE_W],
		idx_q[pnpp_pkg::FL_PAGE_W-1:0]};
	assign ee_waddr = {addr_q[pnpp_pkg::EE_AW-1:pnpp_pkg::EE_PAGE_W],
		idx_q[pnpp_pkg::EE_PAGE_W-1:0]};

	// ----------------------------------------------------------------
	// pin edge history
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_pin_q <= 1'b0;
			wr_n_q <= 1'b1;
			pl_q <= 1'b0;
		end else begin
			clk_pin_q <= load_strobe_clock_pin;
			wr_n_q <= write_strobe_n;
			pl_q <= page_latch_strobe;
		end
	end

	// ----------------------------------------------------------------
	// programming mode entry
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ent_q <= pnpp_pkg::ENT_OFF;
			pulses_q <= '0;
			guard_q <= '0;
		end else if (!hv_reset) begin
			ent_q <= pnpp_pkg::ENT_OFF;
			guard_q <= '0;
			if (clk_rise && pulses_q != pnpp_pkg::ENTRY_PULSES)
				pulses_q <= pulses_q + 3'h1;
		end else begin
			pulses_q <= '0;
			case (ent_q)
				pnpp_pkg::ENT_OFF: begin
					if (pulses_q == pnpp_pkg::ENTRY_PULSES && entry_en_q &&
						pattern == pnpp_pkg::ENTRY_PATTERN) begin
						ent_q <= pnpp_pkg::ENT_GUARD;
						guard_q <= 2'(pnpp_pkg::GUARD_CYC - 1);
					end else begin
						ent_q <= pnpp_pkg::ENT_FAIL;
					end
				end
				pnpp_pkg::ENT_GUARD: begin
					if (pattern != pnpp_pkg::ENTRY_PATTERN)
						ent_q <= pnpp_pkg::ENT_FAIL;
					else if (guard_q == '0)
						ent_q <= pnpp_pkg::ENT_PROG;
					else
						guard_q <= guard_q - 2'h1;
				end
				default: ent_q <= ent_q;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// command, address and data loads
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_q <= pnpp_pkg::CMD_NOP;
			addr_q <= '0;
			dlo_q <= '0;
			dhi_q <= '0;
		end else if (prog && idle && clk_rise) begin
			if (act == pnpp_pkg::ACT_CMD)
				cmd_q <= data_in;
			else if (act == pnpp_pkg::ACT_ADDR && low_high_byte_select)
				addr_q[15:8] <= data_in;
			else if (act == pnpp_pkg::ACT_ADDR)
				addr_q[7:0] <= data_in;
			else if (act == pnpp_pkg::ACT_DATA && low_high_byte_select)
				dhi_q <= data_in;
			else if (act == pnpp_pkg::ACT_DATA)
				dlo_q <= data_in;
		end
	end

	// ----------------------------------------------------------------
	// page buffers and their fill masks
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (prog && idle && pl_rise) begin
			if (cmd_q == pnpp_pkg::CMD_WFLASH && low_high_byte_select)
				fbuf[addr_q[pnpp_pkg::FL_PAGE_W-1:0]] <= {dhi_q, dlo_q};
			else if (cmd_q == pnpp_pkg::CMD_WEEP)
				ebuf[addr_q[pnpp_pkg::EE_PAGE_W-1:0]] <= dlo_q;
		end
	end

	// masks track which words were latched since the last page write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fvalid_q <= '0;
			evalid_q <= '0;
		end else if (prog && idle && clk_rise && act == pnpp_pkg::ACT_CMD &&
			data_in == pnpp_pkg::CMD_NOP && !pl_rise) begin
			fvalid_q <= '0;
			evalid_q <= '0;
		end else if (flash_done) begin
			fvalid_q <= '0;
		end else if (eep_done) begin
			evalid_q <= '0;
		end else if (prog && idle && pl_rise) begin
			if (cmd_q == pnpp_pkg::CMD_WFLASH && low_high_byte_select)
				fvalid_q[addr_q[pnpp_pkg::FL_PAGE_W-1:0]] <= 1'b1;
			else if (cmd_q == pnpp_pkg::CMD_WEEP)
				evalid_q[addr_q[pnpp_pkg::EE_PAGE_W-1:0]] <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// self-timed operation sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= pnpp_pkg::ST_IDLE;
			op_q <= pnpp_pkg::OP_ERASE;
			tmr_q <= '0;
			idx_q <= '0;
			fsel_q <= '0;
			ready_busy_flag <= 1'b1;
		end else begin
			case (st_q)
				pnpp_pkg::ST_IDLE: begin
					idx_q <= '0;
					tmr_q <= pnpp_pkg::TMR_W'(PROG_CYCLES - 1);
					fsel_q <= {extended_byte_select, low_high_byte_select};
					if (prog && wr_fall) begin
						if (cmd_q == pnpp_pkg::CMD_ERASE) begin
							op_q <= pnpp_pkg::OP_ERASE;
							tmr_q <= pnpp_pkg::TMR_W'(ERASE_CYCLES - 1);
							st_q <= pnpp_pkg::ST_WAIT;
							ready_busy_flag <= 1'b0;
						end else if (cmd_q == pnpp_pkg::CMD_WFLASH &&
							!low_high_byte_select) begin
							op_q <= pnpp_pkg::OP_FLASH;
							st_q <= pnpp_pkg::ST_WAIT;
							ready_busy_flag <= 1'b0;
						end else if (cmd_q == pnpp_pkg::CMD_WEEP &&
							!low_high_byte_select) begin
							op_q <= pnpp_pkg::OP_EEP;
							st_q <= pnpp_pkg::ST_WAIT;
							ready_busy_flag <= 1'b0;
						end else if (cmd_q == pnpp_pkg::CMD_WFUSE) begin
							op_q <= pnpp_pkg::OP_FUSE;
							st_q <= pnpp_pkg::ST_WAIT;
							ready_busy_flag <= 1'b0;
						end else if (cmd_q == pnpp_pkg::CMD_WLOCK) begin
							op_q <= pnpp_pkg::OP_LOCK;
							st_q <= pnpp_pkg::ST_WAIT;
							ready_busy_flag <= 1'b0;
						end
					end
				end
				pnpp_pkg::ST_WAIT: begin
					tmr_q <= tmr_q - 1'b1;
					if (tmr_done) begin
						case (op_q)
							pnpp_pkg::OP_FLASH: st_q <= pnpp_pkg::ST_WALK_F;
							pnpp_pkg::OP_EEP: st_q <= pnpp_pkg::ST_WALK_E;
							pnpp_pkg::OP_ERASE: st_q <= pnpp_pkg::ST_ERASE_F;
							default: begin
								st_q <= pnpp_pkg::ST_IDLE;
								ready_busy_flag <= 1'b1;
							end
						endcase
					end
				end
				pnpp_pkg::ST_ERASE_F: begin
					idx_q <= idx_q + 1'b1;
					if (idx_q == '1) begin
						idx_q <= '0;
						if (ee_keep) begin
							st_q <= pnpp_pkg::ST_IDLE;
							ready_busy_flag <= 1'b1;
						end else begin
							st_q <= pnpp_pkg::ST_ERASE_E;
						end
					end
				end
				default: begin
					idx_q <= idx_q + 1'b1;
					if (flash_done || eep_done || erase_e_done) begin
						st_q <= pnpp_pkg::ST_IDLE;
						ready_busy_flag <= 1'b1;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// flash and eeprom arrays
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (st_q == pnpp_pkg::ST_ERASE_F)
			flash_mem[idx_q] <= pnpp_pkg::FL_ERASED;
		else if (st_q == pnpp_pkg::ST_WALK_F &&
			fvalid_q[idx_q[pnpp_pkg::FL_PAGE_W-1:0]])
			flash_mem[fl_waddr] <= flash_mem[fl_waddr] &
				fbuf[idx_q[pnpp_pkg::FL_PAGE_W-1:0]];
	end

	// eeprom erase is skipped entirely when the keep fuse is set
	always_ff @(posedge aclk) begin
		if (st_q == pnpp_pkg::ST_ERASE_E)
			eep_mem[idx_q[pnpp_pkg::EE_AW-1:0]] <= pnpp_pkg::EE_ERASED;
		else if (st_q == pnpp_pkg::ST_WALK_E &&
			evalid_q[idx_q[pnpp_pkg::EE_PAGE_W-1:0]])
			eep_mem[ee_waddr] <= eep_mem[ee_waddr] &
				ebuf[idx_q[pnpp_pkg::EE_PAGE_W-1:0]];
	end

	// ----------------------------------------------------------------
	// fuses and lock bits
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fuse_lo_q <= pnpp_pkg::FUSE_LO_RST;
			fuse_hi_q <= pnpp_pkg::FUSE_HI_RST;
			fuse_ext_q <= pnpp_pkg::FUSE_EXT_RST;
		end else if (fuse_commit && lock_q[pnpp_pkg::LOCK_FUSE_BIT]) begin
			if (fsel_q == 2'b00)
				fuse_lo_q <= dlo_q;
			else if (fsel_q == 2'b01)
				fuse_hi_q <= dlo_q;
			else if (fsel_q == 2'b10)
				fuse_ext_q <= dlo_q;
		end
	end

	// lock bits only move toward programmed, except at the end of the flash erase
	always_ff @(posedge aclk) begin
		if (!aresetn)
			lock_q <= pnpp_pkg::LOCK_RST;
		else if (st_q == pnpp_pkg::ST_ERASE_F && idx_q == '1)
			lock_q <= pnpp_pkg::LOCK_RST;
		else if (lock_commit)
			lock_q <= lock_q & dlo_q;
	end

	// ----------------------------------------------------------------
	// read-back onto the data bus
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_out <= '0;
			data_oe <= 1'b0;
		end else if (prog && !output_enable_n) begin
			data_oe <= 1'b1;
			case (cmd_q)
				pnpp_pkg::CMD_RFLASH:
					data_out <= low_high_byte_select ?
						flash_mem[addr_q[pnpp_pkg::FL_AW-1:0]][15:8] :
						flash_mem[addr_q[pnpp_pkg::FL_AW-1:0]][7:0];
				pnpp_pkg::CMD_REEP:
					data_out <= eep_mem[addr_q[pnpp_pkg::EE_AW-1:0]];
				pnpp_pkg::CMD_RFUSE: begin
					case ({extended_byte_select, low_high_byte_select})
						2'b00: data_out <= fuse_lo_q;
						2'b11: data_out <= fuse_hi_q;
						2'b10: data_out <= fuse_ext_q;
						default: data_out <= lock_q;
					endcase
				end
				default: data_out <= '0;
			endcase
		end else begin
			data_oe <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	logic aw_hit_q;
	logic w_got_q;
	logic [3:0] aw_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= pnpp_pkg::RESP_OKAY;
			aw_hit_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_q <= '0;
			wd_q <= '0;
			ws_q <= '0;
			entry_en_q <= 1'b1;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= s_axi_awaddr[3:0];
				aw_hit_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
				w_got_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_hit_q && w_got_q && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				aw_hit_q <= 1'b0;
				w_got_q <= 1'b0;
				if (aw_q == pnpp_pkg::REG_CTRL) begin
					s_axi_bresp <= pnpp_pkg::RESP_OKAY;
					if (ws_q[0])
						entry_en_q <= wd_q[0];
				end else if (aw_q == pnpp_pkg::REG_STATUS ||
					aw_q == pnpp_pkg::REG_ADDR || aw_q == pnpp_pkg::REG_FUSES) begin
					s_axi_bresp <= pnpp_pkg::RESP_OKAY;
				end else begin
					s_axi_bresp <= pnpp_pkg::RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= pnpp_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= pnpp_pkg::RESP_OKAY;
			if (s_axi_araddr[3:0] == pnpp_pkg::REG_STATUS)
				s_axi_rdata <= {16'h0000, 2'h0, ent_q, st_q, ready_busy_flag, cmd_q};
			else if (s_axi_araddr[3:0] == pnpp_pkg::REG_CTRL)
				s_axi_rdata <= {31'h00000000, entry_en_q};
			else if (s_axi_araddr[3:0] == pnpp_pkg::REG_ADDR)
				s_axi_rdata <= {dhi_q, dlo_q, addr_q};
			else if (s_axi_araddr[3:0] == pnpp_pkg::REG_FUSES)
				s_axi_rdata <= {lock_q, fuse_ext_q, fuse_hi_q, fuse_lo_q};
			else begin
				s_axi_rdata <= '0;
				s_axi_rresp <= pnpp_pkg::RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule

//--- pnpp_prog_model.sv
// Purpose: programmer side of the parallel pins
// Assumes: pins change just after rising clock edges
// Notes: a released bus shows the inverse of the last byte
`timescale 1ns/1ps
module pnpp_prog_model (
	input wire logic aclk,
	input wire logic [7:0] data_in,
	output logic hv_reset,
	output logic load_strobe_clock_pin,
	output logic action_select_hi,
	output logic action_select_lo,
	output logic low_high_byte_select,
	output logic extended_byte_select,
	output logic page_latch_strobe,
	output logic write_strobe_n,
	output logic output_enable_n,
	output logic [7:0] prog_drive
);
	// idle pins at time zero
	initial begin
		{hv_reset, load_strobe_clock_pin, page_latch_strobe} = 3'h0;
		{low_high_byte_select, extended_byte_select} = 2'h0;
		{action_select_hi, action_select_lo} = 2'h3;
		{write_strobe_n, output_enable_n} = 2'h3;
		prog_drive = 8'h00;
	end
	// one load pulse, action and byte select set with it
	task automatic load(input logic [1:0] a, input logic b, input logic [7:0] d);
		@(posedge aclk);
		{action_select_hi, action_select_lo} <= a;
		low_high_byte_select <= b;
		prog_drive <= d;
		load_strobe_clock_pin <= 1'b1;
		@(posedge aclk);
		load_strobe_clock_pin <= 1'b0;
		prog_drive <= ~d;
		@(posedge aclk);
	endtask
	// six pulses, zero pattern, high voltage, then guard wait
	task automatic enter();
		repeat (6) load(2'h3, 1'b0, 8'h00);
		{action_select_hi, action_select_lo} <= 2'h0;
		repeat (3) @(posedge aclk);
		hv_reset <= 1'b1;
		repeat (6) @(posedge aclk);
	endtask
	task automatic latch(input logic b);
		@(posedge aclk);
		low_high_byte_select <= b;
		page_latch_strobe <= 1'b1;
		@(posedge aclk);
		page_latch_strobe <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic wr(input logic b2, input logic b1);
		@(posedge aclk);
		{extended_byte_select, low_high_byte_select} <= {b2, b1};
		@(posedge aclk);
		write_strobe_n <= 1'b0;
		@(posedge aclk);
		write_strobe_n <= 1'b1;
	endtask
	task automatic rd(input logic b2, input logic b1, output logic [7:0] v);
		@(posedge aclk);
		{extended_byte_select, low_high_byte_select} <= {b2, b1};
		output_enable_n <= 1'b0;
		repeat (3) @(posedge aclk);
		v = data_in;
		output_enable_n <= 1'b1;
	endtask
endmodule

//--- tb.sv
// Purpose: self-checking bench for the programming port
// Assumes: shortened program and erase counts
// Notes: expected values kept in bench variables
`timescale 1ns/1ps
module tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic hv_reset, load_strobe_clock_pin, action_select_hi;
	logic action_select_lo, low_high_byte_select, extended_byte_select;
	logic page_latch_strobe, write_strobe_n, output_enable_n;
	logic data_oe, ready_busy_flag;
	logic [7:0] data_in, data_out, prog_drive, v, w0, w1, al, ah, e, lk;
	logic [7:0] fz [3];
	logic [31:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_rdata;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int bad_count = 0;
	int n_tests = 0;
	always #20 aclk = ~aclk;
	// device drives the shared bus only while enabled
	assign data_in = data_oe ? data_out : prog_drive;
	pnpp_port #(.PROG_CYCLES(20), .ERASE_CYCLES(30)) pnpp_port_i (.*);
	pnpp_prog_model pnpp_prog_model_i (.*);
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(string n, logic [7:0] s, logic [7:0] x);
		n_tests++;
		if (s !== x) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic ld(input logic [1:0] a, input logic b, input logic [7:0] d);
		pnpp_prog_model_i.load(a, b, d);
	endtask
	task automatic rdb(input logic b2, input logic b1, input logic [7:0] x);
		pnpp_prog_model_i.rd(b2, b1, v);
		chk("read", v, x);
	endtask
	task automatic wait_rdy();
		int k;
		for (k = 0; k < 40000; k++) begin
			@(posedge aclk);
			if (k > 2 && ready_busy_flag === 1'b1)
				break;
		end
		if (k == 40000) begin
			bad_count++;
			summarize();
		end
	endtask
	task automatic wrw(input logic b2, input logic b1);
		pnpp_prog_model_i.wr(b2, b1);
		wait_rdy();
	endtask
	// one register bus access, w selects write or read
	task automatic ax(input logic w, input logic [31:0] a, input logic [1:0] er,
		input logic [7:0] ed);
		int k;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_araddr} <= {a, a};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
		{s_axi_arvalid, s_axi_rready} <= {2{!w}};
		for (k = 0; k < 99; k++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (w ? s_axi_bvalid : s_axi_rvalid) break;
		end
		{s_axi_bready, s_axi_rready} <= 2'h0;
		chk("resp", {6'h0, w ? s_axi_bresp : s_axi_rresp}, {6'h0, er});
		if (!w) chk("rdata", s_axi_rdata[7:0], ed);
		if (k == 99) begin
			bad_count++;
			summarize();
		end
	endtask
	task automatic erase();
		ld(2'h2, 1'b0, pnpp_pkg::CMD_ERASE);
		wrw(1'b0, 1'b0);
	endtask
	task automatic fcheck();
		ld(2'h2, 1'b0, pnpp_pkg::CMD_RFUSE);
		for (int i = 0; i < 3; i++)
			rdb(i != 0, i == 1, fz[i]);
		rdb(1'b0, 1'b1, lk);
	endtask
	// main sequence
	initial begin
		void'($urandom(32754));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		pnpp_prog_model_i.enter();
		erase();
		al = 8'($urandom);
		ah = 8'($urandom) & 8'h7f;
		w0 = 8'($urandom);
		w1 = 8'($urandom);
		ld(2'h2, 1'b0, pnpp_pkg::CMD_WFLASH);
		ld(2'h0, 1'b0, al);
		ld(2'h1, 1'b0, w0);
		ld(2'h1, 1'b1, w1);
		pnpp_prog_model_i.latch(1'b1);
		ld(2'h0, 1'b1, ah);
		wrw(1'b0, 1'b0);
		ld(2'h2, 1'b0, pnpp_pkg::CMD_NOP);
		ax(1'b0, 32'h0, 2'h0, pnpp_pkg::CMD_NOP);
		ld(2'h2, 1'b0, pnpp_pkg::CMD_RFLASH);
		rdb(1'b0, 1'b0, w0);
		rdb(1'b0, 1'b1, w1);
		e = 8'($urandom);
		ld(2'h2, 1'b0, pnpp_pkg::CMD_WEEP);
		ld(2'h0, 1'b1, ah & 8'h07);
		ld(2'h0, 1'b0, al);
		ld(2'h1, 1'b0, e);
		pnpp_prog_model_i.latch(1'b0);
		wrw(1'b0, 1'b0);
		ld(2'h2, 1'b0, pnpp_pkg::CMD_REEP);
		rdb(1'b0, 1'b0, e);
		for (int i = 0; i < 3; i++) begin
			fz[i] = 8'($urandom);
			if (i == 0) fz[i][3:0] = 4'h0;
			if (i == 1) fz[i][3] = 1'b0;
			ld(2'h2, 1'b0, pnpp_pkg::CMD_WFUSE);
			ld(2'h1, 1'b0, fz[i]);
			wrw(i[1], i[0]);
		end
		lk = 8'($urandom);
		ld(2'h2, 1'b0, pnpp_pkg::CMD_WLOCK);
		ld(2'h1, 1'b0, lk);
		wrw(1'b0, 1'b0);
		fcheck();
		erase();
		lk = 8'hff;
		fcheck();
		ld(2'h2, 1'b0, pnpp_pkg::CMD_RFLASH);
		ld(2'h0, 1'b1, ah);
		rdb(1'b0, 1'b1, 8'hff);
		ld(2'h2, 1'b0, pnpp_pkg::CMD_REEP);
		ld(2'h0, 1'b1, ah & 8'h07);
		rdb(1'b0, 1'b0, e);
		ax(1'b1, 32'h2, 2'h2, 8'h00);
		ax(1'b0, 32'h2, 2'h2, 8'h00);
		ax(1'b1, 32'h4, 2'h0, 8'h00);
		ax(1'b0, 32'h4, 2'h0, 8'h00);
		summarize();
	end
endmodule
